/* hw/ibrgc_pkg.sv */
// shared constants and types of the serial recovery / broadcast block
// assumes one system clock; the bus pins arrive asynchronously
package ibrgc_pkg;
  localparam logic [7:0] GC_ADDR       = 8'h00;  // broadcast address byte
  localparam logic [1:0] OP_WRITE      = 2'h0;
  localparam logic [1:0] OP_INC        = 2'h1;
  localparam logic [1:0] OP_DEC        = 2'h2;
  localparam logic [1:0] OP_READ       = 2'h3;
  localparam logic [3:0] MEM_VOL       = 4'h0;   // volatile wiper location
  localparam logic [3:0] MEM_NV        = 4'h2;   // nonvolatile wiper location
  localparam logic [3:0] CNT_ZERO      = 4'h0;
  localparam logic [3:0] ACK_SLOT      = 4'h8;   // ninth clock of a byte
  localparam logic [3:0] BIT_TOP       = 4'h7;
  localparam int         WIPER_W       = 9;
  localparam logic [8:0] WIPER_MAX     = 9'h100; // full scale
  localparam logic [8:0] WIPER_MID     = 9'h080; // reset value, mid scale
  localparam logic [6:0] DEV_ADDR_DFLT = 7'h2e;  // arbitrary value

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_CMD  = 3'b010,
    ST_DATA = 3'b011,
    ST_TX   = 3'b100
  } ibrgc_state_t;

  typedef enum logic [1:0] {
    DO_NONE = 2'b00,
    DO_INC  = 2'b01,
    DO_DEC  = 2'b10,
    DO_WR   = 2'b11
  } ibrgc_act_t;
endpackage

/* hw/ibrgc_line_if.sv */
// bus events decoded from the synchronised pins
// assumes producer and consumer share clk_sys_i
`timescale 1ns/1ns
interface ibrgc_line_if;
  logic scl_rise;  // one-cycle pulse, clock line went high
  logic scl_fall;  // one-cycle pulse, clock line went low
  logic start;     // one-cycle pulse, start condition
  logic stop;      // one-cycle pulse, stop condition
  logic sda;       // synchronised data line level
  modport src (output scl_rise, scl_fall, start, stop, sda);
  modport snk (input  scl_rise, scl_fall, start, stop, sda);
endinterface // ibrgc_line_if

/* hw/ibrgc_pin_sync.sv */
// two-flop synchronisers for the bus pins and the event decoder
// assumes the bus clock is much slower than clk_sys_i (8 samples or more)
`timescale 1ns/1ns
module ibrgc_pin_sync (
  input  wire logic   clk_sys_i, // system clock
  input  wire logic   rst_b_i,   // async reset, active low
  input  wire logic   scl_i,     // bus clock pin
  input  wire logic   sda_i,     // bus data pin
  ibrgc_line_if.src   ln         // decoded events
);
  localparam int  NCH    = 2;  // channels: clock line, data line
  localparam int  CH_SCL = 1;
  localparam int  CH_SDA = 0;
  logic [NCH-1:0] pin_w;
  logic [NCH-1:0] m_ff;        // first stage, read only by the second
  logic [NCH-1:0] s_ff;        // synchronised level
  logic [NCH-1:0] d_ff;        // one cycle older, for edge detection

  assign pin_w = {scl_i, sda_i};

  // released bus idles high, so reset to high avoids a false edge
  for (genvar g = 0; g < NCH; g++) begin : g_sync
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        m_ff[g] <= 1'b1;
        s_ff[g] <= 1'b1;
        d_ff[g] <= 1'b1;
      end else begin
        m_ff[g] <= pin_w[g];
        s_ff[g] <= m_ff[g];
        d_ff[g] <= s_ff[g];
      end
    end
  end

  wire scl_s = s_ff[CH_SCL];
  wire scl_d = d_ff[CH_SCL];
  wire sda_s = s_ff[CH_SDA];
  wire sda_d = d_ff[CH_SDA];

  assign ln.scl_rise = scl_s & ~scl_d;
  assign ln.scl_fall = ~scl_s & scl_d;
  assign ln.start    = scl_s & scl_d & sda_d & ~sda_s;
  assign ln.stop     = scl_s & scl_d & ~sda_d & sda_s;
  assign ln.sda      = sda_s;
endmodule // ibrgc_pin_sync

/* hw/ibrgc_top.sv */
// serial interface of the potentiometer: recovery and broadcast commands
// assumes an open-drain bus with pull-ups; pins are asynchronous
`timescale 1ns/1ns
module ibrgc_top #(
  parameter logic [6:0] DEV_ADDR = ibrgc_pkg::DEV_ADDR_DFLT
) (
  input  wire logic                        clk_sys_i, // system clock 25 MHz
  input  wire logic                        rst_b_i,   // async reset, low
  input  wire logic                        scl_i,     // bus clock pin
  input  wire logic                        sda_i,     // bus data pin in
  output logic                             sda_o,     // data pin out, low
  output logic                             sda_oe_o,  // high: pull data low
  output logic [ibrgc_pkg::WIPER_W-1:0]    wiper_o,   // volatile wiper
  output logic                             nv_wr_o,   // start nv write pulse
  output logic [ibrgc_pkg::WIPER_W-1:0]    nv_data_o, // value for nv write
  output logic                             busy_o     // transfer in progress
);
  ibrgc_line_if ln ();

  ibrgc_pin_sync u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .scl_i     (scl_i),
    .sda_i     (sda_i),
    .ln        (ln.src)
  );

  ibrgc_pkg::ibrgc_state_t state_ff, post_ff, post_w;
  ibrgc_pkg::ibrgc_act_t   act_ff, act_w;
  logic [3:0]                     cnt_ff;
  logic                           in_ack_ff;
  logic [7:0]                     sh_ff;
  logic [7:0]                     tx_ff;
  logic                           oe_ff;
  logic [3:0]                     mem_ff;
  logic                           d8_ff;
  logic                           gc_ff;
  logic [ibrgc_pkg::WIPER_W-1:0]  wiper_ff;
  logic [ibrgc_pkg::WIPER_W-1:0]  nv_data_ff;
  logic                           nv_pend_ff;
  logic                           nv_wr_ff;

  // byte decode
  wire        dev_match = sh_ff[7:1] == DEV_ADDR;
  wire        gc_hit    = sh_ff == ibrgc_pkg::GC_ADDR;
  wire [1:0]  cmd_op    = sh_ff[3:2];
  wire [3:0]  cmd_mem   = sh_ff[7:4];
  wire        is_vol    = cmd_mem == ibrgc_pkg::MEM_VOL;
  wire        is_nv     = cmd_mem == ibrgc_pkg::MEM_NV;
  // broadcast limited to volatile write/inc/dec
  wire        cmd_ok    = (is_vol && cmd_op != ibrgc_pkg::OP_READ)
                        || (is_nv && cmd_op == ibrgc_pkg::OP_WRITE
                            && !gc_ff);
  wire        at_ack    = cnt_ff == ibrgc_pkg::ACK_SLOT;
  wire        active    = state_ff != ibrgc_pkg::ST_IDLE;
  wire        is_tx     = state_ff == ibrgc_pkg::ST_TX;
  wire        tx_nack   = is_tx && at_ack && in_ack_ff && ln.sda;
  wire        decide    = active && ln.scl_fall && at_ack && !in_ack_ff;
  wire        exec      = active && ln.scl_fall && at_ack && in_ack_ff;
  wire [2:0]  tx_idx    = 3'(ibrgc_pkg::BIT_TOP - cnt_ff);
  wire [ibrgc_pkg::WIPER_W-1:0] wr_raw = {d8_ff, sh_ff};
  wire [ibrgc_pkg::WIPER_W-1:0] wr_val =
    (wr_raw > ibrgc_pkg::WIPER_MAX) ? ibrgc_pkg::WIPER_MAX : wr_raw;
  wire        ack_ok =
    (state_ff == ibrgc_pkg::ST_ADDR) ? (dev_match || gc_hit) :
    (state_ff == ibrgc_pkg::ST_CMD)  ? cmd_ok :
    (state_ff == ibrgc_pkg::ST_DATA);

  always_comb begin
    post_w = ibrgc_pkg::ST_CMD;
    act_w  = ibrgc_pkg::DO_NONE;
    unique case (state_ff)
      ibrgc_pkg::ST_ADDR: begin
        if (dev_match && sh_ff[0])
          post_w = ibrgc_pkg::ST_TX;
      end
      ibrgc_pkg::ST_CMD: begin
        if (cmd_op == ibrgc_pkg::OP_WRITE)
          post_w = ibrgc_pkg::ST_DATA;
        else if (cmd_op == ibrgc_pkg::OP_INC)
          act_w = ibrgc_pkg::DO_INC;
        else if (cmd_op == ibrgc_pkg::OP_DEC)
          act_w = ibrgc_pkg::DO_DEC;
      end
      ibrgc_pkg::ST_DATA: act_w = ibrgc_pkg::DO_WR;
      ibrgc_pkg::ST_TX:   post_w = ibrgc_pkg::ST_TX;
      ibrgc_pkg::ST_IDLE: post_w = ibrgc_pkg::ST_IDLE;
      default:            post_w = ibrgc_pkg::ST_IDLE;
    endcase
  end

  // serial state: start and stop touch only this process and the nv request one
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff  <= ibrgc_pkg::ST_IDLE;
      cnt_ff    <= ibrgc_pkg::CNT_ZERO;
      in_ack_ff <= 1'b0;
      oe_ff     <= 1'b0;
    end else if (ln.start) begin
      state_ff  <= ibrgc_pkg::ST_ADDR;
      cnt_ff    <= ibrgc_pkg::CNT_ZERO;
      in_ack_ff <= 1'b0;
      oe_ff     <= 1'b0;
    end else if (ln.stop) begin
      state_ff  <= ibrgc_pkg::ST_IDLE;
      in_ack_ff <= 1'b0;
      oe_ff     <= 1'b0;
    end else if (ln.scl_rise && active) begin
      if (!at_ack) begin
        cnt_ff <= cnt_ff + 4'h1;
      end else if (tx_nack) begin
        state_ff <= ibrgc_pkg::ST_IDLE;
        oe_ff    <= 1'b0;
      end
    end else if (ln.scl_fall && active) begin
      if (!at_ack) begin
        if (is_tx && cnt_ff != ibrgc_pkg::CNT_ZERO)
          oe_ff <= ~tx_ff[tx_idx];
      end else if (!in_ack_ff) begin
        in_ack_ff <= 1'b1;
        if (is_tx) begin
          oe_ff <= 1'b0;
        end else if (ack_ok) begin
          oe_ff <= 1'b1;
        end else begin
          // not for us or malformed: release and wait for a start
          state_ff <= ibrgc_pkg::ST_IDLE;
          oe_ff    <= 1'b0;
        end
      end else begin
        in_ack_ff <= 1'b0;
        cnt_ff    <= ibrgc_pkg::CNT_ZERO;
        state_ff  <= post_ff;
        oe_ff     <= (post_ff == ibrgc_pkg::ST_TX) ? ~wiper_ff[7] : 1'b0;
      end
    end
  end

  // byte datapath; also holds the decoded next state and action
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sh_ff   <= 8'h00;
      tx_ff   <= 8'h00;
      post_ff <= ibrgc_pkg::ST_IDLE;
      act_ff  <= ibrgc_pkg::DO_NONE;
      mem_ff  <= ibrgc_pkg::MEM_VOL;
      d8_ff   <= 1'b0;
      gc_ff   <= 1'b0;
    end else begin
      if (ln.scl_rise && active && !at_ack)
        sh_ff <= {sh_ff[6:0], ln.sda};
      if (exec)
        tx_ff <= wiper_ff[7:0];
      if (decide) begin
        post_ff <= post_w;
        act_ff  <= is_tx ? ibrgc_pkg::DO_NONE : act_w;
      end
      if (decide && state_ff == ibrgc_pkg::ST_ADDR)
        gc_ff <= gc_hit;
      if (decide && state_ff == ibrgc_pkg::ST_CMD) begin
        mem_ff <= cmd_mem;
        d8_ff  <= sh_ff[0];
      end
    end
  end

  // wiper register; reset only by rst_b_i, never by bus
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wiper_ff <= ibrgc_pkg::WIPER_MID;
    end else if (exec) begin
      unique case (act_ff)
        ibrgc_pkg::DO_INC: if (wiper_ff < ibrgc_pkg::WIPER_MAX)
                             wiper_ff <= wiper_ff + 9'h001;
        ibrgc_pkg::DO_DEC: if (wiper_ff != 9'h000)
                             wiper_ff <= wiper_ff - 9'h001;
        ibrgc_pkg::DO_WR:  if (mem_ff == ibrgc_pkg::MEM_VOL)
                             wiper_ff <= wr_val;
        ibrgc_pkg::DO_NONE: wiper_ff <= wiper_ff;
      endcase
    end
  end

  // a start before the stop cancels the write, so a cut-short command
  // followed by recovery never programs the memory
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      nv_pend_ff <= 1'b0;
      nv_data_ff <= ibrgc_pkg::WIPER_MID;
      nv_wr_ff   <= 1'b0;
    end else begin
      nv_wr_ff <= ln.stop && nv_pend_ff;
      if (ln.start || ln.stop) begin
        nv_pend_ff <= 1'b0;
      end else if (exec && act_ff == ibrgc_pkg::DO_WR
                   && mem_ff == ibrgc_pkg::MEM_NV) begin
        nv_pend_ff <= 1'b1;
        nv_data_ff <= wr_val;
      end
    end
  end

  assign sda_o     = 1'b0;
  assign sda_oe_o  = oe_ff;
  assign wiper_o   = wiper_ff;
  assign nv_wr_o   = nv_wr_ff;
  assign nv_data_o = nv_data_ff;
  assign busy_o    = active;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  chk_start_resets: assert property (ln.start |=>
    state_ff == ibrgc_pkg::ST_ADDR && cnt_ff == ibrgc_pkg::CNT_ZERO)
    else $error("start did not reset serial state");
  chk_start_release: assert property (ln.start |=> !sda_oe_o)
    else $error("data line driven right after start");
  chk_tx_nack_idle: assert property (ln.scl_rise && tx_nack |=>
    state_ff == ibrgc_pkg::ST_IDLE ##1 !sda_oe_o)
    else $error("missing master ack did not reset interface");
  // idle after a nack lasts until the next start, so this covers the gap
  chk_held_low_free: assert property (!busy_o |-> !sda_oe_o)
    else $error("data line driven again before a new start");
  chk_start_cancel: assert property (ln.start |=>
    !nv_pend_ff ##1 !nv_wr_o)
    else $error("second start did not cancel nv write");
  chk_nv_on_stop: assert property (nv_wr_o |->
    $past(ln.stop) && $past(nv_pend_ff))
    else $error("nv write not tied to stop after command");
  chk_stop_idle: assert property (ln.stop |=>
    state_ff == ibrgc_pkg::ST_IDLE && !sda_oe_o && !busy_o)
    else $error("stop did not idle the interface");
  chk_wiper_kept: assert property ((ln.start || ln.stop) |=>
    $stable(wiper_o))
    else $error("bus framing changed the wiper");
  chk_gc_accept: assert property (decide &&
    state_ff == ibrgc_pkg::ST_ADDR && gc_hit |=> sda_oe_o && gc_ff)
    else $error("broadcast address not acknowledged");

  cov_read_byte: cover property (ln.start ##[1:400] is_tx);
  cov_nv_write:  cover property (nv_wr_o);
  cov_gc_exec:   cover property (exec && gc_ff
                                 && act_ff != ibrgc_pkg::DO_NONE);
  cov_recovery:  cover property (tx_nack ##[1:400] ln.start);
endmodule // ibrgc_top

/* test/ibrgc_bus_master.sv */
// behavioural bus master for the serial recovery / broadcast block
// assumes pull-ups on both lines; the bench resolves the data wire
`timescale 1ns/1ns
module ibrgc_bus_master (
  input  wire logic clk_i,     // bench clock, 8 cycles per bus bit
  input  wire logic sda_i,     // resolved data wire
  output logic      scl_o,     // bus clock, stands high between frames
  output logic      sda_low_o  // high: master pulls data low
);
  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // data changes mid low phase, sampled at the end of the high phase
  task automatic bit_io(input logic v, output logic r);
    tick(2);
    sda_low_o <= ~v;
    tick(2);
    scl_o <= 1'b1;
    tick(4);
    r = sda_i;
    scl_o <= 1'b0;
  endtask
  task automatic start();
    tick(1);
    sda_low_o <= 1'b0;
    tick(3);
    scl_o <= 1'b1;
    tick(4);
    sda_low_o <= 1'b1;
    tick(4);
    scl_o <= 1'b0;
  endtask
  task automatic stop();
    tick(1);
    sda_low_o <= 1'b1;
    tick(3);
    scl_o <= 1'b1;
    tick(4);
    sda_low_o <= 1'b0;
    tick(4);
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, ack);
  endtask
  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nack, r);
  endtask
  task automatic recover();
    logic r;
    start();
    // nine ones read as a reserved address that other devices ignore
    for (int i = 0; i < 9; i++) bit_io(1'b1, r);
    start();
    stop();
  endtask
endmodule // ibrgc_bus_master

/* test/testbench.sv */
// self-checking bench: master model drives the pins, queue holds expected updates
// assumes the design package and the master model are compiled first
`timescale 1ns/1ns
module testbench;
  localparam logic [6:0] DEV = 7'h35;
  logic        clk_sys_i, rst_b_i, scl, sda_low, sda_o, sda_oe_o;
  logic        nv_wr_o, busy_o, ack;
  logic [8:0]  wiper_o, nv_data_o, exp_w, prev_w;
  logic [7:0]  rd;
  logic [9:0]  notes[$];
  logic [31:0] lf;
  int          n_mismatch, check_count;
  wire         sda_w = ~(sda_low | (sda_oe_o & ~sda_o));
  ibrgc_top #(.DEV_ADDR(DEV)) dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .wiper_o(wiper_o), .nv_wr_o(nv_wr_o), .nv_data_o(nv_data_o),
    .busy_o(busy_o));
  ibrgc_bus_master u_master (.clk_i(clk_sys_i), .sda_i(sda_w),
    .scl_o(scl), .sda_low_o(sda_low));
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // an unexpected update finds no note and fails against its own inverse
  task automatic take(input logic [9:0] v);
    logic [9:0] e;
    e = (notes.size() > 0) ? notes.pop_front() : ~v;
    check(v, e);
  endtask
  always @(posedge clk_sys_i) begin
    if (rst_b_i === 1'b1 && nv_wr_o === 1'b1) take({1'b1, nv_data_o});
    if (rst_b_i === 1'b1 && wiper_o !== prev_w) take({1'b0, wiper_o});
    prev_w <= wiper_o;
  end
  task automatic addr(input logic [7:0] a, input logic n);
    u_master.start();
    u_master.wr_byte(a, ack);
    check(10'(ack), 10'(n));
  endtask
  task automatic cmd(input logic [7:0] c, input logic [7:0] d);
    logic [8:0] w;
    w = exp_w;
    u_master.wr_byte(c, ack);
    check(10'(ack), 10'h000);
    if (c[3:2] == ibrgc_pkg::OP_WRITE) begin
      u_master.wr_byte(d, ack);
      check(10'(ack), 10'h000);
      w = ({c[0], d} > ibrgc_pkg::WIPER_MAX) ? ibrgc_pkg::WIPER_MAX
                                            : {c[0], d};
    end
    if (c[3:2] == ibrgc_pkg::OP_INC && w < ibrgc_pkg::WIPER_MAX) w++;
    if (c[3:2] == ibrgc_pkg::OP_DEC && w > 9'h000) w--;
    if (c[7:4] == ibrgc_pkg::MEM_NV) notes.push_back({1'b1, w});
    else if (w != exp_w) notes.push_back({1'b0, w});
    if (c[7:4] == ibrgc_pkg::MEM_VOL) exp_w = w;
  endtask
  task automatic idle_chk();
    repeat (8) @(posedge clk_sys_i);
    check({8'h00, sda_oe_o, busy_o}, 10'h000);
  endtask
  initial begin
    rst_b_i = 1'b0;
    lf = 32'h3cce;
    exp_w = ibrgc_pkg::WIPER_MID;
    repeat (12) @(posedge clk_sys_i);
    check({sda_oe_o, wiper_o}, 10'h080);
    check({busy_o, nv_data_o}, 10'h080);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    addr({DEV, 1'b0}, 1'b0);
    cmd(8'h00, 8'h55);
    for (int i = 0; i < 4; i++) begin
      lf = lfsr(lf);
      cmd({7'h00, lf[8]}, lf[7:0]);
    end
    cmd(8'h01, 8'hff);
    cmd(8'h04, 8'h00);
    cmd(8'h08, 8'h00);
    u_master.stop();
    addr(8'h00, 1'b0);
    cmd(8'h00, 8'h12);
    cmd(8'h04, 8'h00);
    cmd(8'h08, 8'h00);
    cmd(8'h08, 8'h00);
    u_master.wr_byte(8'h0c, ack);
    check(10'(ack), 10'h001);
    idle_chk();
    addr(8'h00, 1'b0);
    u_master.wr_byte(8'h20, ack);
    check(10'(ack), 10'h001);
    u_master.stop();
    addr({~DEV, 1'b0}, 1'b1);
    idle_chk();
    u_master.stop();
    addr({DEV, 1'b0}, 1'b0);
    cmd(8'h20, 8'h33);
    u_master.stop();
    // partial data byte, then a start drops it
    addr({DEV, 1'b0}, 1'b0);
    u_master.wr_byte(8'h00, ack);
    for (int i = 0; i < 4; i++) u_master.bit_io(1'b0, ack);
    u_master.start();
    u_master.stop();
    idle_chk();
    addr({DEV, 1'b0}, 1'b0);
    cmd(8'h00, 8'h0f);
    u_master.stop();
    addr({DEV, 1'b1}, 1'b0);
    u_master.rd_byte(1'b0, rd);
    check({2'b00, rd}, {2'b00, exp_w[7:0]});
    u_master.rd_byte(1'b1, rd);
    check({2'b00, rd}, {2'b00, exp_w[7:0]});
    idle_chk();
    // device left driving a zero read bit
    addr({DEV, 1'b1}, 1'b0);
    for (int i = 0; i < 3; i++) u_master.bit_io(1'b1, ack);
    u_master.recover();
    idle_chk();
    // nv write cut short while the device acks, then recovery
    addr({DEV, 1'b0}, 1'b0);
    u_master.wr_byte(8'h20, ack);
    for (int i = 7; i >= 0; i--) u_master.bit_io(i[0], ack);
    u_master.recover();
    idle_chk();
    addr({DEV, 1'b0}, 1'b0);
    cmd(8'h04, 8'h00);
    u_master.stop();
    repeat (20) @(posedge clk_sys_i);
    check(10'(notes.size()), 10'h000);
    complete_run();
  end
  initial begin
    repeat (30000) @(posedge clk_sys_i);
    n_mismatch++;
    complete_run();
  end
endmodule // testbench
